// ===== hw/csa_pkg.sv
package csa_pkg;

  // ----------------------------------------------------------------------
  // Record layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] INPUT_INSTANCE   = 8'h47;
  localparam int         RECORD_BYTES     = 4;
  localparam int         FLAG_FAULT       = 0;
  localparam int         FLAG_WARNING     = 1;
  localparam int         FLAG_RUNNING     = 2;
  localparam int         FLAG_REGEN       = 3;
  localparam int         FLAG_READY       = 4;
  localparam int         FLAG_NET_CTRL    = 5;
  localparam int         FLAG_NET_REF     = 6;
  localparam int         FLAG_SPARE       = 7;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int         CLOCK_PERIOD_NS  = 100;
  localparam int         TICK_NS          = 1000;
  localparam int         TICK_CYCLES      = (TICK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG      = 8'h00;
  localparam logic [7:0] ADDR_COMMAND     = 8'h04;
  localparam logic [7:0] ADDR_REQ_O2T     = 8'h08;
  localparam logic [7:0] ADDR_REQ_T2O     = 8'h0c;
  localparam logic [7:0] ADDR_MULTIPLIER  = 8'h10;
  localparam logic [7:0] ADDR_STATUS      = 8'h14;
  localparam logic [7:0] ADDR_RECORD      = 8'h18;
  localparam logic [7:0] ADDR_INSTANCE    = 8'h1c;
  localparam logic [7:0] ADDR_CONSUMED    = 8'h40;
  localparam logic [7:0] ADDR_PRODUCED    = 8'h44;
  localparam logic [3:0] SLOT_PAGE_0      = 4'h2;
  localparam logic [3:0] SLOT_PAGE_1      = 4'h3;
  localparam logic [3:0] SLOT_REQ_O2T     = 4'h0;
  localparam logic [3:0] SLOT_ACT_O2T     = 4'h4;
  localparam logic [3:0] SLOT_REQ_T2O     = 4'h8;
  localparam logic [3:0] SLOT_ACT_T2O     = 4'hc;

  // Command and status bits.
  localparam int         CMD_OPEN         = 0;
  localparam int         CMD_CLOSE        = 1;
  localparam int         CMD_SLOT         = 2;
  localparam int         STAT_ACTIVE      = 0;
  localparam int         STAT_REFUSED     = 2;
  localparam int         STAT_TIMEOUT     = 3;
  localparam int         SCALE_WIDTH      = 4;

endpackage

// ===== hw/csa_top.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Record FIFO
// ----------------------------------------------------------------------
module csa_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 count;
    logic                        full;
    logic                        valid;
    logic [WIDTH-1:0]            head;
  } csa_fifo_state_type;

  csa_fifo_state_type s;
  csa_fifo_state_type next_s;
  logic               push;
  logic               pop;

  always_comb begin
    next_s = s;
    push   = in_valid && !s.full;
    pop    = out_ready && s.valid;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + AW'(1);
    end
    if (pop) begin
      next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + AW'(1);
    end
    case ({push, pop})
      2'b10:   next_s.count = s.count + (AW+1)'(1);
      2'b01:   next_s.count = s.count - (AW+1)'(1);
      default: next_s.count = s.count;
    endcase
    next_s.full  = (next_s.count == (AW+1)'(DEPTH));
    next_s.valid = (next_s.count != '0);
    next_s.head  = next_s.mem[next_s.rd];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Full, valid and the head word are registered copies taken from the next count and read pointer,
  // so the stream outputs come straight from flops at no cost in latency.
  assign in_ready  = !s.full;
  assign out_valid = s.valid;
  assign out_data  = s.head;
endmodule // csa_fifo

// ----------------------------------------------------------------------
// Status record assembly and connection supervision
// ----------------------------------------------------------------------
module csa_top #(
  parameter int SLOTS       = 2,
  parameter int FIFO_DEPTH  = 16,
  parameter int TIME_WIDTH  = 24,
  parameter int COUNT_WIDTH = 32
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB register port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Converter core status
  input  wire logic        fault,
  input  wire logic        warning,
  input  wire logic        running,
  input  wire logic        regenerating,
  input  wire logic        converter_ready,
  input  wire logic        run_from_network,
  input  wire logic        voltage_from_network,
  input  wire logic [7:0]  supervisor_state,
  input  wire logic [15:0] output_voltage,
  // Packets consumed from the master
  input  wire logic        consume_valid,
  input  wire logic        consume_slot,
  // Records produced toward the master
  output logic             record_valid,
  input  wire logic        record_ready,
  output logic [31:0]      record_data
);
  typedef struct packed {
    logic                  active;
    logic [TIME_WIDTH-1:0] req_o2t;
    logic [TIME_WIDTH-1:0] req_t2o;
    logic [7:0]            multiplier;
    logic [TIME_WIDTH-1:0] since_o2t;
    logic [TIME_WIDTH-1:0] since_t2o;
    logic [TIME_WIDTH-1:0] act_o2t;
    logic [TIME_WIDTH-1:0] act_t2o;
  } csa_slot_type;

  typedef struct packed {
    logic [SLOTS-1:0]                  slot_active;
    csa_slot_type [SLOTS-1:0]          slot;
    logic [csa_pkg::SCALE_WIDTH-1:0]   scale;
    logic [TIME_WIDTH-1:0]             stage_o2t;
    logic [TIME_WIDTH-1:0]             stage_t2o;
    logic [7:0]                        stage_mult;
    logic                              refused;
    logic [SLOTS-1:0]                  timed_out;
    logic [31:0]                       record;
    logic [COUNT_WIDTH-1:0]            consumed;
    logic [COUNT_WIDTH-1:0]            produced;
    logic [7:0]                        tick_count;
    logic [31:0]                       prdata;
    logic                              pready;
    logic                              pslverr;
  } csa_state_type;

  csa_state_type s;
  csa_state_type next_s;
  logic          push_valid;
  logic          push_ready;
  logic          tick;
  logic          slot_due [SLOTS];
  logic          wr_access;
  logic [31:0]   rd_value;
  logic          mapped;
  logic [15:0]   scaled;
  logic [31:0]   limit;
  logic          placed;
  int            pick;

  // ----------------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------------
  always_comb begin
    rd_value = '0;
    mapped   = 1'b1;
    case (paddr)
      csa_pkg::ADDR_CONFIG:     rd_value = 32'(s.scale);
      csa_pkg::ADDR_COMMAND:    rd_value = '0;
      csa_pkg::ADDR_REQ_O2T:    rd_value = 32'(s.stage_o2t);
      csa_pkg::ADDR_REQ_T2O:    rd_value = 32'(s.stage_t2o);
      csa_pkg::ADDR_MULTIPLIER: rd_value = 32'(s.stage_mult);
      csa_pkg::ADDR_STATUS: begin
        rd_value[csa_pkg::STAT_ACTIVE +: SLOTS]  = s.slot_active;
        rd_value[csa_pkg::STAT_REFUSED]          = s.refused;
        rd_value[csa_pkg::STAT_TIMEOUT +: SLOTS] = s.timed_out;
      end
      csa_pkg::ADDR_RECORD:     rd_value = s.record;
      csa_pkg::ADDR_INSTANCE:   rd_value = 32'(csa_pkg::INPUT_INSTANCE);
      csa_pkg::ADDR_CONSUMED:   rd_value = 32'(s.consumed);
      csa_pkg::ADDR_PRODUCED:   rd_value = 32'(s.produced);
      default: begin
        if (paddr[7:4] == csa_pkg::SLOT_PAGE_0 || paddr[7:4] == csa_pkg::SLOT_PAGE_1) begin
          case (paddr[3:0])
            csa_pkg::SLOT_REQ_O2T: rd_value = 32'(s.slot[paddr[4]].req_o2t);
            csa_pkg::SLOT_ACT_O2T: rd_value = 32'(s.slot[paddr[4]].act_o2t);
            csa_pkg::SLOT_REQ_T2O: rd_value = 32'(s.slot[paddr[4]].req_t2o);
            csa_pkg::SLOT_ACT_T2O: rd_value = 32'(s.slot[paddr[4]].act_t2o);
            default:               mapped   = 1'b0;
          endcase
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s     = s;
    tick       = (s.tick_count == 8'(csa_pkg::TICK_CYCLES - 1));
    wr_access  = psel && penable && s.pready && pwrite && !s.pslverr;
    push_valid = 1'b0;
    placed     = 1'b0;
    pick       = 0;
    limit      = '0;
    scaled     = 16'(output_voltage << s.scale);

    // The microsecond tick paces every interval counter.
    next_s.tick_count = tick ? '0 : s.tick_count + 8'h01;

    // The record is rebuilt every cycle from the converter's live status.
    next_s.record[csa_pkg::FLAG_FAULT]     = fault;
    next_s.record[csa_pkg::FLAG_WARNING]   = warning;
    next_s.record[csa_pkg::FLAG_RUNNING]   = running;
    next_s.record[csa_pkg::FLAG_REGEN]     = regenerating;
    next_s.record[csa_pkg::FLAG_READY]     = converter_ready;
    next_s.record[csa_pkg::FLAG_NET_CTRL]  = run_from_network;
    next_s.record[csa_pkg::FLAG_NET_REF]   = voltage_from_network;
    next_s.record[csa_pkg::FLAG_SPARE]     = 1'b0;
    next_s.record[15:8]                    = supervisor_state;
    next_s.record[23:16]                   = scaled[7:0];
    next_s.record[31:24]                   = scaled[15:8];

    // APB answers one cycle after setup, so pready always comes from a flop.
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    if (psel && !penable) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !mapped;
      next_s.prdata  = pwrite ? 32'h0000_0000 : rd_value;
    end

    // Per-slot interval tracking, measurement and supervision.
    for (int i = 0; i < SLOTS; i++) begin
      slot_due[i] = s.slot[i].active && (s.slot[i].since_t2o >= s.slot[i].req_t2o);
      limit = 32'(s.slot[i].req_o2t) * 32'(s.slot[i].multiplier);
      if (s.slot[i].active) begin
        if (tick && s.slot[i].since_o2t != '1) begin
          next_s.slot[i].since_o2t = s.slot[i].since_o2t + TIME_WIDTH'(1);
        end
        if (tick && s.slot[i].since_t2o != '1) begin
          next_s.slot[i].since_t2o = s.slot[i].since_t2o + TIME_WIDTH'(1);
        end
        if (consume_valid && consume_slot == 1'(i)) begin
          next_s.slot[i].act_o2t   = s.slot[i].since_o2t;
          next_s.slot[i].since_o2t = '0;
        end else if (tick && 32'(s.slot[i].since_o2t) >= limit) begin
          next_s.slot[i].active  = 1'b0;
          next_s.timed_out[i]    = 1'b1;
        end
      end
    end

    // Consumed packets count only when they land on an open connection.
    if (consume_valid && s.slot[consume_slot].active) begin
      next_s.consumed = s.consumed + COUNT_WIDTH'(1);
    end

    // Lowest due slot produces first; a full FIFO holds the slot due until space frees.
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (slot_due[i]) begin
        pick = i;
      end
    end
    if (slot_due[pick]) begin
      push_valid = 1'b1;
      if (push_ready) begin
        next_s.slot[pick].act_t2o   = s.slot[pick].since_t2o;
        next_s.slot[pick].since_t2o = '0;
        next_s.produced             = s.produced + COUNT_WIDTH'(1);
      end
    end

    // Register writes.
    if (wr_access) begin
      case (paddr)
        csa_pkg::ADDR_CONFIG:     next_s.scale      = pwdata[csa_pkg::SCALE_WIDTH-1:0];
        csa_pkg::ADDR_REQ_O2T:    next_s.stage_o2t  = pwdata[TIME_WIDTH-1:0];
        csa_pkg::ADDR_REQ_T2O:    next_s.stage_t2o  = pwdata[TIME_WIDTH-1:0];
        csa_pkg::ADDR_MULTIPLIER: next_s.stage_mult = pwdata[7:0];
        csa_pkg::ADDR_STATUS: begin
          // Write one to clear; a fresh event in the same cycle keeps its flag.
          if (pwdata[csa_pkg::STAT_REFUSED]) begin
            next_s.refused = 1'b0;
          end
          for (int i = 0; i < SLOTS; i++) begin
            if (pwdata[csa_pkg::STAT_TIMEOUT + i] && !(s.slot[i].active && !next_s.slot[i].active)) begin
              next_s.timed_out[i] = 1'b0;
            end
          end
        end
        csa_pkg::ADDR_COMMAND: begin
          if (pwdata[csa_pkg::CMD_CLOSE]) begin
            next_s.slot[pwdata[csa_pkg::CMD_SLOT]].active = 1'b0;
          end else if (pwdata[csa_pkg::CMD_OPEN]) begin
            for (int i = 0; i < SLOTS; i++) begin
              if (!placed && !s.slot[i].active) begin
                placed                     = 1'b1;
                next_s.slot[i].active      = 1'b1;
                next_s.slot[i].req_o2t     = s.stage_o2t;
                next_s.slot[i].req_t2o     = s.stage_t2o;
                next_s.slot[i].multiplier  = s.stage_mult;
                next_s.slot[i].since_o2t   = '0;
                next_s.slot[i].since_t2o   = '0;
                next_s.slot[i].act_o2t     = '0;
                next_s.slot[i].act_t2o     = '0;
              end
            end
            if (!placed) begin
              next_s.refused = 1'b1;
            end
          end
        end
        default: begin
          next_s.refused = s.refused;
        end
      endcase
    end

    for (int i = 0; i < SLOTS; i++) begin
      next_s.slot_active[i] = next_s.slot[i].active;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Only the power-up reset clears the message counters; no register write reaches them.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Record FIFO
  // ----------------------------------------------------------------------
  csa_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (s.record),
    .out_valid (record_valid),
    .out_ready (record_ready),
    .out_data  (record_data)
  );

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
endmodule // csa_top

// ===== tb/csa_master_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Network master: drains records and sends cyclic packets
// ----------------------------------------------------------------------
module csa_master_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Record stream
  input  wire logic        record_valid,
  input  wire logic [31:0] record_data,
  output logic             record_ready,
  // Packets toward the block
  output logic             consume_valid,
  output logic             consume_slot,
  // A stalling master refuses records until released.
  input  wire logic        stall
);
  logic [31:0] got[$];

  assign record_ready = !stall;

  always @(posedge clock) begin
    if (rst_n && record_valid && record_ready) begin
      got.push_back(record_data);
    end
  end

  initial begin
    consume_valid = 1'b0;
    consume_slot  = 1'b0;
  end

  // The slot line is inverted once released, so a stale value never passes.
  task send(input logic slot);
    @(posedge clock);
    consume_valid <= 1'b1;
    consume_slot  <= slot;
    @(posedge clock);
    consume_valid <= 1'b0;
    consume_slot  <= ~slot;
  endtask
endmodule // csa_master_model

// ===== tb/csa_top_asserts.sv
`timescale 1ns/1ps
module csa_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core status
  input wire logic        fault,
  input wire logic        warning,
  input wire logic        running,
  input wire logic        regenerating,
  input wire logic        converter_ready,
  input wire logic        run_from_network,
  input wire logic        voltage_from_network,
  input wire logic [7:0]  supervisor_state,
  // Record stream
  input wire logic        record_valid,
  input wire logic        record_ready,
  input wire logic [31:0] record_data
);
  logic       setup;
  logic [7:0] flags;

  assign setup = psel && !penable;
  assign flags = {1'b0, voltage_from_network, run_from_network, converter_ready,
                  regenerating, running, warning, fault};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_PREADY_ONE: assert property (setup |=> pready) else $error("pready missing after setup");
  AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_UNMAPPED: assert property (setup && paddr >= 8'h48 |=> pslverr) else $error("unmapped not refused");
  AST_INSTANCE: assert property (setup && !pwrite && paddr == 8'h1c |=> prdata[7:0] == 8'h47)
    else $error("instance id wrong");
  // The record register lags the core by one cycle, so only steady inputs are judged.
  AST_REC_FLAGS: assert property ($past(rst_n) && setup && !pwrite && paddr == 8'h18 && $stable(flags)
    |=> prdata[7:0] == $past(flags)) else $error("record flags wrong");
  AST_REC_STATE: assert property ($past(rst_n) && setup && !pwrite && paddr == 8'h18 && $stable(supervisor_state)
    |=> prdata[15:8] == $past(supervisor_state)) else $error("record state wrong");
  AST_SPARE_ZERO: assert property (record_valid |-> !record_data[7]) else $error("spare flag set");
  AST_REC_HOLD: assert property (record_valid && !record_ready |=> record_valid && $stable(record_data))
    else $error("record lost while stalled");

  cover property (setup && !pwrite && paddr == 8'h18);
  cover property (record_valid && record_ready);
  cover property (pslverr);
endmodule // csa_checker

bind csa_top csa_checker u_checker (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault(fault), .warning(warning),
  .running(running), .regenerating(regenerating), .converter_ready(converter_ready),
  .run_from_network(run_from_network), .voltage_from_network(voltage_from_network),
  .supervisor_state(supervisor_state), .record_valid(record_valid), .record_ready(record_ready),
  .record_data(record_data)
);

// ===== tb/tb_csa_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_csa_top;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, err, stall;
  logic        record_valid, record_ready, consume_valid, consume_slot;
  logic [7:0]  paddr, state;
  logic [31:0] pwdata, prdata, record_data, rd;
  logic [6:0]  flg;
  logic [15:0] volt;
  int          num_errors, checks_done, cyc;

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  csa_top dut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault(flg[0]),
    .warning(flg[1]), .running(flg[2]), .regenerating(flg[3]), .converter_ready(flg[4]),
    .run_from_network(flg[5]), .voltage_from_network(flg[6]), .supervisor_state(state),
    .output_voltage(volt), .consume_valid(consume_valid), .consume_slot(consume_slot),
    .record_valid(record_valid), .record_ready(record_ready), .record_data(record_data)
  );

  csa_master_model master (
    .clock(clock), .rst_n(rst_n), .record_valid(record_valid), .record_data(record_data),
    .record_ready(record_ready), .consume_valid(consume_valid), .consume_slot(consume_slot), .stall(stall)
  );

  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  task vrec(input logic [3:0] s, input logic [15:0] v, input logic [15:0] w);
    apb(1'b1, 8'h00, {28'h0, s});
    @(posedge clock);
    volt <= v;
    repeat (2) @(posedge clock);
    rchk("voltage", 8'h18, {w, state, 1'b0, flg});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_ident;
    rchk("instance", 8'h1c, 32'h47);
    apb(1'b1, 8'h50, 32'h1);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, 8'h40, 32'h1234);
    rchk("count read only", 8'h40, 32'h0);
  endtask

  task t_record;
    logic [6:0] f;
    for (int i = 0; i < 8; i++) begin
      f = (i == 7) ? 7'h7f : 7'(1 << i);
      @(posedge clock);
      flg <= f;
      state <= 8'(8'h11 * i);
      repeat (2) @(posedge clock);
      rchk("flags", 8'h18, {16'h0, 8'(8'h11 * i), 1'b0, f});
    end
    vrec(4'h2, 16'h0400, 16'h1000);
    vrec(4'h0, 16'habcd, 16'habcd);
    vrec(4'hf, 16'h0003, 16'h8000);
  endtask

  // A stalled master must leave sixteen records waiting and no more produced.
  task t_conn;
    @(posedge clock);
    stall <= 1'b1;
    apb(1'b1, 8'h08, 32'd5);
    apb(1'b1, 8'h0c, 32'd2);
    apb(1'b1, 8'h10, 32'd40);
    repeat (3) apb(1'b1, 8'h04, 32'h1);
    rchk("third open refused", 8'h14, 32'h7);
    repeat (400) @(negedge clock);
    `CHK("valid held", 1'b1, record_valid)
    rchk("produced full", 8'h44, 32'd16);
    @(posedge clock);
    stall <= 1'b0;
    master.send(1'b0);
    repeat (2) begin
      repeat (29) @(posedge clock);
      master.send(1'b0);
    end
    rchk("req interval", 8'h20, 32'd5);
    rchk("act interval", 8'h24, 32'd3);
    apb(1'b1, 8'h04, 32'h2);
    apb(1'b1, 8'h04, 32'h6);
    master.send(1'b0);
    repeat (100) @(negedge clock);
    apb(1'b1, 8'h40, 32'h0);
    rchk("consumed", 8'h40, 32'd3);
    rchk("produced", 8'h44, master.got.size());
    rchk("act t2o", 8'h2c, 32'd2);
    rchk("slot1 req t2o", 8'h38, 32'd2);
    `CHK("first record", {16'h8000, state, 1'b0, flg}, master.got[0])
  endtask

  task t_timeout;
    apb(1'b1, 8'h14, 32'h1c);
    apb(1'b1, 8'h10, 32'd4);
    apb(1'b1, 8'h04, 32'h1);
    repeat (150) @(negedge clock);
    rchk("alive", 8'h14, 32'h1);
    repeat (100) @(negedge clock);
    rchk("timed out", 8'h14, 32'h8);
    apb(1'b1, 8'h14, 32'h8);
    rchk("cleared", 8'h14, 32'h0);
  endtask

  task final_report;
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    flg = 7'h0; state = 8'h0; volt = 16'h0; stall = 1'b0; num_errors = 0; checks_done = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_ident;
    t_record;
    t_conn;
    t_timeout;
    final_report;
  end

  initial begin
    cyc = 0;
    while (cyc < 20000) begin
      @(posedge clock);
      cyc++;
    end
    num_errors++;
    final_report;
  end
endmodule // tb_csa_top
